// ==== fraction_numerator_pll_divider_slip_ctrl.sv ====
`timescale 1ns/1ns
// Summary of operation
// - output frequency is pfd rate times integer plus fraction over modulus, post-divided
// - pfd rate is reference times doubler factor over count times halving factor
// - doubler counts both reference edges before the reference counter
// - halving inserts a toggle stage giving an even pfd duty cycle
// - modulus is a full twelve-bit programmable field
// - reference division factor sits in a ten-bit counter
// - reference ratio runs one to 1023; host never programs zero
// - imminent slip with reduction active enables one extra cell, sourcing or sinking
// - enabled extra cells drive steady current, never pulsed
// - each further imminent slip before overshoot enables another extra cell, up to seven
// - after overshoot, extra cells turn off one by one until none
// - at most seven extra cells are enabled together
// - slip reduction is enabled only by bit 18 of register three
// - low three bits of each word select the register; 0,1,1 selects three
module fraction_numerator_pll_divider_slip_ctrl #(
	parameter int DATA_W = 32
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [2:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	input wire logic reference_input,
	input wire logic slip_imminent,
	input wire logic tune_up,
	input wire logic overshoot,
	output logic pfd_clk,
	output logic pfd_event,
	output logic [16:0] feedback_divide,
	output logic [2:0] output_post_divider,
	output logic [6:0] extra_cell_en,
	output logic extra_cell_source
);
	typedef struct packed {
		logic [5:0][31:0] cfg;
		logic ref_s1;
		logic ref_s2;
		logic ref_d;
		logic imm_s1;
		logic imm_s2;
		logic imm_d;
		logic ovs_s1;
		logic ovs_s2;
		logic dir_s1;
		logic dir_s2;
		logic [9:0] rcnt;
		logic half;
		logic pfd_pulse;
		logic [11:0] acc;
		logic [16:0] ndiv;
		logic [2:0] cells;
		logic source;
		fraction_numerator_pll_pkg::slip_state_t state;
		logic [31:0] rdata;
	} state_t;

	state_t st;
	state_t next_st;

	logic [15:0] int_val;
	logic [11:0] fraction_numerator_val;
	logic [11:0] mod_val;
	logic [9:0] r_val;
	logic doubler;
	logic halve;
	logic cnt_reset;
	logic slip_en;
	logic ref_event;
	logic terminal;
	logic pfd_tick;
	logic imm_rise;
	logic [12:0] acc_sum;
	logic [31:0] status_word;
	logic [6:0] therm;
	logic [2:0] wsel;

	assign int_val = st.cfg[fraction_numerator_pll_pkg::REG_INT_FRACTION_NUMERATOR][fraction_numerator_pll_pkg::INT_LSB +: fraction_numerator_pll_pkg::INT_W];
	assign fraction_numerator_val = st.cfg[fraction_numerator_pll_pkg::REG_INT_FRACTION_NUMERATOR][fraction_numerator_pll_pkg::FRACTION_NUMERATOR_LSB +:
		fraction_numerator_pll_pkg::FRACTION_NUMERATOR_W];
	assign mod_val = st.cfg[fraction_numerator_pll_pkg::REG_MODULUS][fraction_numerator_pll_pkg::MOD_LSB +: fraction_numerator_pll_pkg::MOD_W];
	assign r_val = st.cfg[fraction_numerator_pll_pkg::REG_REFERENCE][fraction_numerator_pll_pkg::RCNT_LSB +:
		fraction_numerator_pll_pkg::RCNT_W];
	assign doubler = st.cfg[fraction_numerator_pll_pkg::REG_REFERENCE][fraction_numerator_pll_pkg::DOUBLER_BIT];
	assign halve = st.cfg[fraction_numerator_pll_pkg::REG_REFERENCE][fraction_numerator_pll_pkg::HALVE_BIT];
	assign cnt_reset = st.cfg[fraction_numerator_pll_pkg::REG_REFERENCE][fraction_numerator_pll_pkg::COUNTER_RESET_BIT];
	assign slip_en = st.cfg[fraction_numerator_pll_pkg::REG_SLIP][fraction_numerator_pll_pkg::SLIP_ENABLE_BIT];
	assign wsel = wdata[fraction_numerator_pll_pkg::SEL_LSB +: fraction_numerator_pll_pkg::SEL_W];

	// doubler uses both edges, else falling edge only
	assign ref_event = doubler ? (st.ref_s2 ^ st.ref_d) : (st.ref_d & ~st.ref_s2);
	// a zero ratio behaves as one
	assign terminal = ref_event && !cnt_reset && ({1'b0, st.rcnt} + 11'h001 >= {1'b0, r_val});
	// halving passes every second terminal count
	assign pfd_tick = terminal && (!halve || st.half);
	// rising edge of the synchronised slip warning
	assign imm_rise = st.imm_s2 & ~st.imm_d;
	assign acc_sum = {1'b0, st.acc} + {1'b0, fraction_numerator_val};

	// thermometer enables; a cell stays on steadily while counted
	genvar gi;
	generate
		for (gi = 0; gi < fraction_numerator_pll_pkg::MAX_CELLS; gi++)
		begin : g_cell
			assign therm[gi] = (st.cells > 3'(gi));
		end
	endgenerate

	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[fraction_numerator_pll_pkg::STAT_CELLS_LSB +: fraction_numerator_pll_pkg::CELL_W] = st.cells;
		status_word[fraction_numerator_pll_pkg::STAT_SOURCE_BIT] = st.source;
		status_word[fraction_numerator_pll_pkg::STAT_ACTIVE_BIT] = (st.state != fraction_numerator_pll_pkg::SLIP_IDLE);
		status_word[fraction_numerator_pll_pkg::STAT_PFD_BIT] = halve ? st.half : st.pfd_pulse;
	end

	always_comb
	begin
		next_st = st;
		// pin synchronisers
		next_st.ref_s1 = reference_input;
		next_st.ref_s2 = st.ref_s1;
		next_st.ref_d = st.ref_s2;
		next_st.imm_s1 = slip_imminent;
		next_st.imm_s2 = st.imm_s1;
		next_st.imm_d = st.imm_s2;
		next_st.ovs_s1 = overshoot;
		next_st.ovs_s2 = st.ovs_s1;
		next_st.dir_s1 = tune_up;
		next_st.dir_s2 = st.dir_s1;
		next_st.pfd_pulse = 1'b0;

		if (wr && (wdata[fraction_numerator_pll_pkg::SEL_LSB +: fraction_numerator_pll_pkg::SEL_W] <= fraction_numerator_pll_pkg::REG_OUTPUT))
		begin
			next_st.cfg[wdata[fraction_numerator_pll_pkg::SEL_LSB +: fraction_numerator_pll_pkg::SEL_W]] = wdata[31:0];
		end

		next_st.rdata = 32'h0000_0000;
		if (rd)
		begin
			if (addr <= fraction_numerator_pll_pkg::REG_OUTPUT)
			begin
				next_st.rdata = st.cfg[addr];
			end
			else if (addr == fraction_numerator_pll_pkg::REG_STATUS)
			begin
				next_st.rdata = status_word;
			end
		end

		if (cnt_reset)
		begin
			next_st.rcnt = fraction_numerator_pll_pkg::RCNT_RST;
			next_st.half = 1'b0;
			next_st.acc = fraction_numerator_pll_pkg::ACC_RST;
		end
		else if (ref_event)
		begin
			if (terminal)
			begin
				next_st.rcnt = fraction_numerator_pll_pkg::RCNT_RST;
				next_st.half = ~st.half;
				next_st.pfd_pulse = 1'b1;
			end
			else
			begin
				next_st.rcnt = st.rcnt + 10'h001;
			end
		end

		// per pfd cycle divide is integer or integer plus one
		if (pfd_tick)
		begin
			if (mod_val != 12'h000 && acc_sum >= {1'b0, mod_val})
			begin
				next_st.acc = 12'(acc_sum - {1'b0, mod_val});
				next_st.ndiv = {1'b0, int_val} + 17'h00001;
			end
			else
			begin
				next_st.acc = acc_sum[11:0];
				next_st.ndiv = {1'b0, int_val};
			end
		end

		// new fraction or modulus restarts the accumulator
		// so a smaller modulus never leaves a residue above it
		if (wr && (wsel == fraction_numerator_pll_pkg::REG_INT_FRACTION_NUMERATOR || wsel == fraction_numerator_pll_pkg::REG_MODULUS))
		begin
			next_st.acc = fraction_numerator_pll_pkg::ACC_RST;
		end

		if (!slip_en)
		begin
			next_st.cells = 3'h0;
			next_st.state = fraction_numerator_pll_pkg::SLIP_IDLE;
		end
		else
		begin
			case (st.state)
				fraction_numerator_pll_pkg::SLIP_IDLE:
				begin
					if (imm_rise)
					begin
						next_st.cells = 3'h1;
						next_st.source = st.dir_s2;
						next_st.state = fraction_numerator_pll_pkg::SLIP_ACQUIRE;
					end
				end
				fraction_numerator_pll_pkg::SLIP_ACQUIRE:
				begin
					if (st.ovs_s2)
					begin
						next_st.state = fraction_numerator_pll_pkg::SLIP_RELEASE;
					end
					else if (imm_rise && st.cells < 3'(fraction_numerator_pll_pkg::MAX_CELLS))
					begin
						next_st.cells = st.cells + 3'h1;
					end
				end
				fraction_numerator_pll_pkg::SLIP_RELEASE:
				begin
					// one cell off per pfd cycle
					if (pfd_tick)
					begin
						if (st.cells <= 3'h1)
						begin
							next_st.cells = 3'h0;
							next_st.state = fraction_numerator_pll_pkg::SLIP_IDLE;
						end
						else
						begin
							next_st.cells = st.cells - 3'h1;
						end
					end
				end
				default:
				begin
					next_st.cells = 3'h0;
					next_st.state = fraction_numerator_pll_pkg::SLIP_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		// reset loads the power-up register words
		if (sys_rst)
		begin
			st <= '0;
			st.cfg[0] <= fraction_numerator_pll_pkg::RST_REG0;
			st.cfg[1] <= fraction_numerator_pll_pkg::RST_REG1;
			st.cfg[2] <= fraction_numerator_pll_pkg::RST_REG2;
			st.cfg[3] <= fraction_numerator_pll_pkg::RST_REG3;
			st.cfg[4] <= fraction_numerator_pll_pkg::RST_REG4;
			st.cfg[5] <= fraction_numerator_pll_pkg::RST_REG5;
			st.state <= fraction_numerator_pll_pkg::SLIP_IDLE;
		end
		// ce low freezes every register, strobes included
		else if (ce)
		begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;
	// pfd output after doubler, counter and halving
	assign pfd_clk = halve ? st.half : st.pfd_pulse;
	// combinational so the tick is seen in its own cycle
	assign pfd_event = pfd_tick & ce;
	assign feedback_divide = st.ndiv;
	assign output_post_divider = st.cfg[fraction_numerator_pll_pkg::REG_OUTPUT][fraction_numerator_pll_pkg::POST_DIV_LSB +:
		fraction_numerator_pll_pkg::POST_DIV_W];
	assign extra_cell_en = slip_en ? therm : 7'h00;
	assign extra_cell_source = st.source;
endmodule

// ==== fraction_numerator_pll_pkg.sv ====
package fraction_numerator_pll_pkg;
	// register indices selected by the low three bits of a written word
	localparam logic [2:0] REG_INT_FRACTION_NUMERATOR = 3'h0;
	localparam logic [2:0] REG_MODULUS = 3'h1;
	localparam logic [2:0] REG_REFERENCE = 3'h2;
	localparam logic [2:0] REG_SLIP = 3'h3;
	localparam logic [2:0] REG_RESERVED = 3'h4;
	localparam logic [2:0] REG_OUTPUT = 3'h5;
	localparam logic [2:0] REG_STATUS = 3'h6;
	localparam int NUM_CFG = 6;
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 3;
	// field layout
	localparam int INT_LSB = 15;
	localparam int INT_W = 16;
	localparam int FRACTION_NUMERATOR_LSB = 3;
	localparam int FRACTION_NUMERATOR_W = 12;
	localparam int MOD_LSB = 3;
	localparam int MOD_W = 12;
	localparam int RCNT_LSB = 14;
	localparam int RCNT_W = 10;
	localparam int DOUBLER_BIT = 25;
	localparam int HALVE_BIT = 24;
	localparam int COUNTER_RESET_BIT = 3;
	localparam int SLIP_ENABLE_BIT = 18;
	localparam int POST_DIV_LSB = 20;
	localparam int POST_DIV_W = 3;
	// status word layout
	localparam int STAT_CELLS_LSB = 0;
	localparam int STAT_SOURCE_BIT = 3;
	localparam int STAT_ACTIVE_BIT = 4;
	localparam int STAT_PFD_BIT = 5;
	// slip reduction
	localparam int MAX_CELLS = 7;
	localparam int CELL_W = 3;
	// values after reset: reference counter 1, modulus 2
	localparam logic [31:0] RST_REG0 = 32'h0000_0000;
	localparam logic [31:0] RST_REG1 = 32'h0000_0011;
	localparam logic [31:0] RST_REG2 = 32'h0000_4002;
	localparam logic [31:0] RST_REG3 = 32'h0000_0003;
	localparam logic [31:0] RST_REG4 = 32'h0080_0004;
	localparam logic [31:0] RST_REG5 = 32'h0000_0005;
	localparam logic [9:0] RCNT_RST = 10'h000;
	localparam logic [11:0] ACC_RST = 12'h000;
	typedef enum logic [2:0] {
		SLIP_IDLE = 3'b001,
		SLIP_ACQUIRE = 3'b010,
		SLIP_RELEASE = 3'b100
	} slip_state_t;
endpackage

// ==== fraction_numerator_pll_host.sv ====
`timescale 1ns/1ns
module fraction_numerator_pll_host (
	input wire logic clk,
	input wire logic start,
	input wire logic [5:0][31:0] words,
	output logic wr,
	output logic [31:0] wdata
);
	int k = -1;
	always @(posedge clk)
	begin
		wr <= k >= 0;
		wdata <= k >= 0 ? words[k] : ~wdata;
		if (start)
			k <= 5;
		else if (k >= 0)
			k <= k - 1;
	end
endmodule

// ==== fraction_numerator_pll_sva.sv ====
`timescale 1ns/1ns
module fraction_numerator_pll_sva (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic slip_imminent,
	input wire logic pfd_event,
	input wire logic [2:0] output_post_divider,
	input wire logic [6:0] extra_cell_en,
	input wire logic extra_cell_source
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [2:0] n;
	assign n = 3'($countones(extra_cell_en));
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data outside read cycle");
	a_cells_thermo: assert property (extra_cell_en == 7'((8'h01 << n) - 1))
		else $error("extra cells not a thermometer");
	a_cell_rise: assert property (n > $past(n) |-> n == $past(n) + 1
		&& $past(slip_imminent, 2) && !$past(slip_imminent, 4))
		else $error("cell added without slip");
	a_cell_fall: assert property (n < $past(n) && n != 0
		|-> n == $past(n) - 1 && $past(pfd_event))
		else $error("cell removed wrongly");
	a_cell_steady: assert property (n != 0 && $past(n) != 0 |-> $stable(extra_cell_source))
		else $error("direction moved while cells on");
	a_slip_off: assert property (ce && wr && wdata[2:0] == 3'h3 && !wdata[18]
		|-> ##2 extra_cell_en == 7'h00)
		else $error("cells on while disabled");
	a_post_div: assert property (ce && wr && wdata[2:0] == 3'h5
		|-> ##2 output_post_divider == $past(wdata[22:20], 2))
		else $error("post divider not loaded");
	a_pfd_single: assert property (pfd_event |=> !pfd_event)
		else $error("pfd event longer than a cycle");
endmodule
bind fraction_numerator_pll_divider_slip_ctrl fraction_numerator_pll_sva sva_u (
	.clk(clk),
	.sys_rst(sys_rst),
	.ce(ce),
	.wdata(wdata),
	.wr(wr),
	.rd(rd),
	.rdata(rdata),
	.slip_imminent(slip_imminent),
	.pfd_event(pfd_event),
	.output_post_divider(output_post_divider),
	.extra_cell_en(extra_cell_en),
	.extra_cell_source(extra_cell_source)
);

// ==== test_fraction_numerator_pll_divider_slip_ctrl.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
	$display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module test_fraction_numerator_pll_divider_slip_ctrl;
	localparam int H = 3;
	logic clk = 0, sys_rst = 1, ce = 1, rd = 0, ref_in = 0, slip = 0, up = 0, over = 0;
	logic start = 0, wr, pfd_event, src, pclk;
	logic [2:0] addr = 0;
	logic [31:0] wdata, rdata;
	logic [16:0] fb;
	logic [6:0] cells;
	logic [5:0][31:0] w;
	int fails = 0, n_compared = 0, cyc = 0, r, d, md, fr, in, s, g, hi;
	fraction_numerator_pll_divider_slip_ctrl dut_u (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.reference_input(ref_in),
		.slip_imminent(slip),
		.tune_up(up),
		.overshoot(over),
		.pfd_clk(pclk),
		.pfd_event(pfd_event),
		.feedback_divide(fb),
		.output_post_divider(),
		.extra_cell_en(cells),
		.extra_cell_source(src)
	);
	fraction_numerator_pll_host host_u (
		.clk(clk),
		.start(start),
		.words(w),
		.wr(wr),
		.wdata(wdata)
	);
	initial
	begin
		forever #20 clk = ~clk;
	end
	// reference half period is H clocks, edges kept off the clock edges
	initial
	begin
		#7;
		forever #(H * 40) ref_in = ~ref_in;
	end
	always @(posedge clk)
	begin
		if (++cyc > 20000)
		begin
			fails++;
			wrap_up;
		end
	end
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cfg(input logic en);
		r = 1 + $urandom % 4;
		d = $urandom % 2;
		md = 2 + $urandom % 8;
		fr = $urandom % md;
		in = 20 + $urandom % 100;
		w[0] = {1'b0, 16'(in), 12'(fr), 3'h0};
		w[1] = {17'h0, 12'(md), 3'h1};
		w[2] = {6'h0, 1'(d), 1'b1, 10'(r), 11'h0, 3'h2};
		w[3] = {13'h0, en, 15'h0, 3'h3};
		w[4] = fraction_numerator_pll_pkg::RST_REG4;
		w[5] = {9'h0, 3'($urandom), 17'h0, 3'h5};
		@(posedge clk) start <= 1;
		@(posedge clk) start <= 0;
		repeat (9) @(posedge clk);
	endtask
	task automatic rdchk(input logic [2:0] a, input logic [31:0] e);
		@(posedge clk)
		begin
			rd <= 1;
			addr <= a;
		end
		@(posedge clk) rd <= 0;
		@(negedge clk) `CHK(rdata, e)
	endtask
	task automatic gap(output int n);
		n = 0;
		hi = 0;
		do
		begin
			@(negedge clk);
			n++;
			if (pclk === 1'b1)
				hi++;
		end
		while (pfd_event !== 1'b1);
	endtask
	task automatic bump(input int k);
		@(posedge clk) slip <= 1;
		repeat (5) @(posedge clk);
		slip <= 0;
		repeat (5) @(negedge clk);
		`CHK(cells, 7'((8'h01 << k) - 1))
	endtask
	initial
	begin
		void'($urandom(32'hC9EA));
		repeat (2) @(posedge clk);
		sys_rst <= 0;
		repeat (3)
		begin
			cfg(1);
			for (int i = 0; i < 6; i++)
				rdchk(3'(i), w[i]);
			rdchk(3'h7, 32'h0);
			repeat (2) gap(g);
			`CHK(hi * 2, g)
			`CHK(g, r * 2 * (d ? H : 2 * H))
			s = 0;
			repeat (md)
			begin
				gap(g);
				s += fb;
			end
			`CHK(s, in * md + fr)
		end
		@(posedge clk) up <= 1'($urandom);
		for (int k = 1; k < 10; k++)
			bump(k > 7 ? 7 : k);
		@(posedge clk)
		begin
			rd <= 1;
			addr <= 3'h6;
		end
		@(posedge clk) rd <= 0;
		@(negedge clk) `CHK(rdata[4:0], {1'b1, up, 3'h7})
		`CHK(src, up)
		@(posedge clk) over <= 1;
		repeat (500) @(posedge clk);
		over <= 0;
		repeat (5) @(negedge clk);
		`CHK(cells, 7'h00)
		// a slip warning while ce is low is never seen
		@(posedge clk) ce <= 0;
		bump(0);
		@(posedge clk) ce <= 1;
		bump(1);
		cfg(0);
		@(negedge clk);
		`CHK(cells, 7'h00)
		bump(0);
		wrap_up;
	end
endmodule
